// ### hdl/sac_pkg.sv
package sac_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int RES_W  = 13;
	localparam int MAG_W  = 12;
	localparam int BYTE_W = 8;
	localparam int CNT_W  = 11;
	localparam int IDX_W  = 4;
	localparam int EXT_W  = BYTE_W - (RES_W - BYTE_W);

	// ----------------------------------------------------------------
	// Sequence lengths in converter clock periods
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] AZ_CYCLES  = 11'd26;
	localparam logic [CNT_W-1:0] ACQ_CYCLES = 11'd7;
	localparam logic [CNT_W-1:0] CAL_CYCLES = 11'd1399;
	localparam logic [CNT_W-1:0] CNT_ONE    = 11'd1;
	localparam logic [CNT_W-1:0] CNT_ZERO   = 11'd0;

	// ----------------------------------------------------------------
	// Bit positions, masks and reset values
	// ----------------------------------------------------------------
	localparam int SIGN_BIT = RES_W - 1;
	localparam logic [IDX_W-1:0]  MSB_IDX   = 4'hb;
	localparam logic [IDX_W-1:0]  LSB_IDX   = 4'h0;
	localparam logic [IDX_W-1:0]  IDX_ONE   = 4'h1;
	localparam logic [BYTE_W-1:0] TEST_MASK = 8'h6c;
	localparam logic [BYTE_W-1:0] OE_ALL    = 8'hff;
	localparam logic [BYTE_W-1:0] OE_NONE   = 8'h00;
	localparam logic [RES_W-1:0]  RES_RST   = 13'h0000;
	localparam logic [MAG_W-1:0]  MAG_ZERO  = 12'h000;
	localparam logic [MAG_W-1:0]  MAG_ONE   = 12'h001;
	localparam int EDGE_N = 4;
	localparam int E_WR   = 0;
	localparam int E_TH   = 1;
	localparam int E_RD   = 2;
	localparam int E_CAL  = 3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE, ST_CAL, ST_ARMED, ST_AZ, ST_ACQ, ST_TRACK,
		ST_SIGN, ST_BITS, ST_STORE, ST_DRAIN
	} sac_state_t;

	typedef struct packed {
		logic chip_select_n;
		logic write_strobe_n;
		logic read_strobe_n;
		logic track_hold_n;
		logic calibrate_n;
		logic autozero_n;
	} sac_host_in_t;

	typedef struct packed {
		logic [BYTE_W-1:0] data;
		logic [BYTE_W-1:0] oe;
	} sac_bus_out_t;

	typedef struct packed {
		logic [MAG_W-1:0] code;
		logic             sign_test;
		logic             track;
	} sac_analog_t;

endpackage : sac_pkg

// ### hdl/sac_edge.sv
`timescale 1ns/1ps
module sac_edge #(
	parameter int N = 4
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         srst,
	// Sampled levels and their edges
	input  wire logic [N-1:0] level,
	output logic      [N-1:0] fall,
	output logic      [N-1:0] rise
);

	typedef struct packed {
		logic [N-1:0] prev;
	} sac_edge_st_t;

	sac_edge_st_t st_reg;
	sac_edge_st_t st_next;

	always_comb
	begin
		st_next      = st_reg;
		st_next.prev = level;
	end

	always_ff @(posedge mclk)
	begin
		// Strobes idle high, so reset assumes all released
		if (srst)
			st_reg <= '{prev: '1};
		else
			st_reg <= st_next;
	end

	assign fall = st_reg.prev & ~level;
	assign rise = ~st_reg.prev & level;

endmodule : sac_edge

// ### hdl/sac_buf.sv
`timescale 1ns/1ps
module sac_buf #(
	parameter int W     = 13,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         srst,
	// Filling side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Draining side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);

	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wp;
		logic [PW-1:0]           rp;
		logic [PW:0]             cnt;
	} sac_buf_st_t;

	sac_buf_st_t st_reg;
	sac_buf_st_t st_next;

	logic push;
	logic pop;

	assign in_ready  = st_reg.cnt != (PW+1)'(DEPTH);
	assign out_valid = st_reg.cnt != '0;
	assign out_data  = st_reg.mem[st_reg.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb
	begin
		st_next = st_reg;
		if (push)
		begin
			st_next.mem[st_reg.wp] = in_data;
			st_next.wp = (st_reg.wp == PW'(DEPTH - 1)) ? '0 : st_reg.wp + PW'(1);
		end
		if (pop)
			st_next.rp = (st_reg.rp == PW'(DEPTH - 1)) ? '0 : st_reg.rp + PW'(1);
		if (push && !pop)
			st_next.cnt = st_reg.cnt + (PW+1)'(1);
		else if (pop && !push)
			st_next.cnt = st_reg.cnt - (PW+1)'(1);
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

endmodule : sac_buf

// ### hdl/sac_core.sv
`timescale 1ns/1ps
module sac_core (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 srst,
	// Host control pins
	input  wire sac_pkg::sac_host_in_t host_in,
	// Host data port and status
	output sac_pkg::sac_bus_out_t     bus_out,
	output logic                      conversion_done,
	output logic                      result_ready_irq_n,
	// Analog front end
	input  wire logic                 comp_high,
	output sac_pkg::sac_analog_t      analog
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		sac_pkg::sac_state_t              state;
		logic [sac_pkg::CNT_W-1:0]        cnt;
		logic [sac_pkg::IDX_W-1:0]        idx;
		logic [sac_pkg::MAG_W-1:0]        mag;
		logic                             sign;
		logic                             az_mode;
		logic [sac_pkg::RES_W-1:0]        push_data;
		logic                             push_vld;
		logic [sac_pkg::RES_W-1:0]        out_res;
		logic                             ptr_lo;
		logic                             irq_n;
		logic                             done;
		logic [sac_pkg::BYTE_W-1:0]       db_data;
		logic [sac_pkg::BYTE_W-1:0]       db_oe;
	} sac_core_st_t;

	sac_core_st_t st_reg;
	sac_core_st_t st_next;

	// ----------------------------------------------------------------
	// Edge detection and qualification
	// ----------------------------------------------------------------
	logic [sac_pkg::EDGE_N-1:0] fall;
	logic [sac_pkg::EDGE_N-1:0] rise;
	logic                       cs;
	logic                       wr_fall;
	logic                       wr_rise;
	logic                       th_fall;
	logic                       th_rise;
	logic                       rd_rise;
	logic                       rd_act;
	logic                       cal_start;
	logic                       test_mode;

	sac_edge #(
		.N (sac_pkg::EDGE_N)
	) u_edge (
		.mclk  (mclk),
		.srst  (srst),
		.level ({host_in.calibrate_n, host_in.read_strobe_n,
		         host_in.track_hold_n, host_in.write_strobe_n}),
		.fall  (fall),
		.rise  (rise)
	);

	assign cs        = !host_in.chip_select_n;
	assign wr_fall   = cs && fall[sac_pkg::E_WR];
	assign wr_rise   = cs && rise[sac_pkg::E_WR];
	assign th_fall   = cs && fall[sac_pkg::E_TH];
	assign th_rise   = cs && rise[sac_pkg::E_TH];
	assign rd_rise   = cs && rise[sac_pkg::E_RD];
	assign rd_act    = cs && !host_in.read_strobe_n;
	assign cal_start = fall[sac_pkg::E_CAL] && host_in.chip_select_n
	                   && host_in.track_hold_n;
	assign test_mode = cs && !host_in.calibrate_n && host_in.read_strobe_n;

	// ----------------------------------------------------------------
	// Result buffer between the converter and the output register
	// ----------------------------------------------------------------
	logic                      buf_in_ready;
	logic                      buf_out_valid;
	logic                      buf_out_ready;
	logic [sac_pkg::RES_W-1:0] buf_out_data;

	// Output register only reloads between read pairs, so a half-read
	// result is never torn; the buffer absorbs the wait.
	assign buf_out_ready = !st_reg.ptr_lo && !rd_act && !rd_rise;

	sac_buf #(
		.W     (sac_pkg::RES_W),
		.DEPTH (2)
	) u_buf (
		.mclk      (mclk),
		.srst      (srst),
		.in_valid  (st_reg.push_vld),
		.in_ready  (buf_in_ready),
		.in_data   (st_reg.push_data),
		.out_valid (buf_out_valid),
		.out_ready (buf_out_ready),
		.out_data  (buf_out_data)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	logic [sac_pkg::MAG_W-1:0] bit_mask;
	logic [sac_pkg::RES_W-1:0] signed_res;

	assign bit_mask   = sac_pkg::MAG_ONE << st_reg.idx;
	assign signed_res = st_reg.sign ? sac_pkg::RES_W'(-{1'b0, st_reg.mag})
	                                : {1'b0, st_reg.mag};

	always_comb
	begin
		st_next = st_reg;

		unique case (st_reg.state)
			sac_pkg::ST_IDLE, sac_pkg::ST_ARMED, sac_pkg::ST_TRACK:
				;
			sac_pkg::ST_CAL:
			begin
				if (st_reg.cnt == sac_pkg::CNT_ONE)
					st_next.state = sac_pkg::ST_IDLE;
				st_next.cnt = st_reg.cnt - sac_pkg::CNT_ONE;
			end
			sac_pkg::ST_AZ:
			begin
				if (st_reg.cnt == sac_pkg::CNT_ONE)
				begin
					st_next.state = sac_pkg::ST_ACQ;
					st_next.cnt   = sac_pkg::ACQ_CYCLES;
				end
				else
					st_next.cnt = st_reg.cnt - sac_pkg::CNT_ONE;
			end
			sac_pkg::ST_ACQ:
			begin
				if (st_reg.cnt == sac_pkg::CNT_ONE)
					st_next.state = sac_pkg::ST_SIGN;
				else
					st_next.cnt = st_reg.cnt - sac_pkg::CNT_ONE;
			end
			sac_pkg::ST_SIGN:
			begin
				// Held input above ground means positive: sign low
				st_next.sign  = !comp_high;
				st_next.idx   = sac_pkg::MSB_IDX;
				st_next.mag   = sac_pkg::MAG_ZERO;
				st_next.state = sac_pkg::ST_BITS;
			end
			sac_pkg::ST_BITS:
			begin
				if (comp_high)
					st_next.mag = st_reg.mag | bit_mask;
				if (st_reg.idx == sac_pkg::LSB_IDX)
					st_next.state = sac_pkg::ST_STORE;
				else
					st_next.idx = st_reg.idx - sac_pkg::IDX_ONE;
			end
			sac_pkg::ST_STORE:
			begin
				st_next.push_data = signed_res;
				st_next.push_vld  = 1'b1;
				st_next.state     = sac_pkg::ST_DRAIN;
			end
			sac_pkg::ST_DRAIN:
			begin
				if (st_reg.push_vld && buf_in_ready)
					st_next.push_vld = 1'b0;
				// Done rises only once the result sits in the output register
				if (!st_reg.push_vld && !buf_out_valid)
					st_next.state = sac_pkg::ST_IDLE;
			end
		endcase

		// Conversion starts abort anything except calibration
		if (st_reg.state != sac_pkg::ST_CAL)
		begin
			if (wr_fall)
			begin
				st_next.state    = sac_pkg::ST_ARMED;
				st_next.push_vld = 1'b0;
			end
			else if (wr_rise)
			begin
				st_next.push_vld = 1'b0;
				st_next.az_mode  = !host_in.autozero_n;
				if (!host_in.autozero_n)
				begin
					st_next.state = sac_pkg::ST_AZ;
					st_next.cnt   = sac_pkg::AZ_CYCLES;
				end
				else
					st_next.state = sac_pkg::ST_SIGN;
			end
			else if (th_fall)
			begin
				st_next.state    = sac_pkg::ST_TRACK;
				st_next.push_vld = 1'b0;
				st_next.az_mode  = 1'b0;
			end
			else if (th_rise && st_reg.state == sac_pkg::ST_TRACK)
				st_next.state = sac_pkg::ST_SIGN;
			if (cal_start)
			begin
				st_next.state    = sac_pkg::ST_CAL;
				st_next.cnt      = sac_pkg::CAL_CYCLES;
				st_next.push_vld = 1'b0;
			end
		end

		// Byte pointer and interrupt
		if (rd_rise)
			st_next.ptr_lo = !st_reg.ptr_lo;
		if (rd_act)
			st_next.irq_n = 1'b1;
		// A new result wins over a read clearing the interrupt
		if (buf_out_valid && buf_out_ready)
		begin
			st_next.out_res = buf_out_data;
			st_next.ptr_lo  = 1'b0;
			st_next.irq_n   = 1'b0;
		end

		// Done is high only while idle, waiting, tracking or acquiring
		unique case (st_next.state)
			sac_pkg::ST_IDLE, sac_pkg::ST_ARMED, sac_pkg::ST_TRACK, sac_pkg::ST_ACQ:
				st_next.done = 1'b1;
			default:
				st_next.done = 1'b0;
		endcase

		// Data port
		st_next.db_data = st_next.ptr_lo
		                  ? st_next.out_res[sac_pkg::BYTE_W-1:0]
		                  : {{sac_pkg::EXT_W{st_next.out_res[sac_pkg::SIGN_BIT]}},
		                     st_next.out_res[sac_pkg::SIGN_BIT:sac_pkg::BYTE_W]};
		if (rd_act)
			st_next.db_oe = sac_pkg::OE_ALL;
		else if (test_mode)
			st_next.db_oe = sac_pkg::TEST_MASK;
		else
			st_next.db_oe = sac_pkg::OE_NONE;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		// Reset runs the power-up calibration, which cannot be cut short
		if (srst)
		begin
			st_reg           <= '0;
			st_reg.state     <= sac_pkg::ST_CAL;
			st_reg.cnt       <= sac_pkg::CAL_CYCLES;
			st_reg.out_res   <= sac_pkg::RES_RST;
			st_reg.irq_n     <= 1'b1;
			st_reg.done      <= 1'b0;
			st_reg.db_oe     <= sac_pkg::OE_NONE;
		end
		else
			st_reg <= st_next;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign conversion_done    = st_reg.done;
	assign result_ready_irq_n = st_reg.irq_n;
	assign bus_out.data       = st_reg.db_data;
	assign bus_out.oe         = st_reg.db_oe;
	assign analog.code        = (st_reg.state == sac_pkg::ST_BITS)
	                            ? (st_reg.mag | bit_mask) : st_reg.mag;
	assign analog.sign_test   = st_reg.state == sac_pkg::ST_SIGN;
	assign analog.track       = st_reg.done;

endmodule : sac_core

// ### bench/sac_core_monitor.sv
`timescale 1ns/1ps
module sac_core_monitor (
	// Clock and reset
	input wire logic                  mclk,
	input wire logic                  srst,
	// Watched ports
	input wire sac_pkg::sac_host_in_t host_in,
	input wire sac_pkg::sac_bus_out_t bus_out,
	input wire logic                  conversion_done,
	input wire logic                  result_ready_irq_n,
	input wire logic                  comp_high,
	input wire sac_pkg::sac_analog_t  analog
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);

	// ------------------------------------------------------------
	// Run lengths of the done level and sequence tracking
	// ------------------------------------------------------------
	logic [10:0] low_reg;
	logic [10:0] high_reg;
	logic        cal_reg;
	logic        az_reg;
	logic        acq_reg;
	logic        restart;

	// A write or track start aborts a run, so its nulling and acquisition tracking is dropped
	assign restart = !host_in.chip_select_n
	                 && (!host_in.write_strobe_n || !host_in.track_hold_n);

	always_ff @(posedge mclk)
	begin
		low_reg  <= conversion_done ? 11'h000 : low_reg + 11'h001;
		high_reg <= conversion_done ? high_reg + 11'h001 : 11'h000;
		if (srst)
		begin
			cal_reg <= 1'b0;
			az_reg  <= 1'b0;
			acq_reg <= 1'b0;
		end
		else
		begin
			// Only a start while done is high is tracked, so an abort never confuses the counts
			if (conversion_done && !host_in.calibrate_n && host_in.chip_select_n
				&& host_in.track_hold_n)
				cal_reg <= 1'b1;
			else if (conversion_done && low_reg != 11'h000)
				cal_reg <= 1'b0;
			if (restart)
				az_reg <= 1'b0;
			else if ($rose(host_in.write_strobe_n) && !host_in.chip_select_n
				&& !host_in.autozero_n && conversion_done)
				az_reg <= 1'b1;
			else if (conversion_done && low_reg != 11'h000)
				az_reg <= 1'b0;
			if (restart)
				acq_reg <= 1'b0;
			else if (az_reg && conversion_done && low_reg != 11'h000)
				acq_reg <= 1'b1;
			else if (!conversion_done && high_reg != 11'h000)
				acq_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	a_cs_blocks_out: assert property (host_in.chip_select_n [*2] |=>
		bus_out.oe == 8'h00) else $error("outputs driven without select");
	a_read_drives: assert property ((!host_in.chip_select_n && !host_in.read_strobe_n) [*2]
		|=> bus_out.oe == 8'hff) else $error("read does not drive the bus");
	a_test_bits: assert property ((!host_in.chip_select_n && !host_in.calibrate_n
		&& host_in.read_strobe_n) [*2] |=> bus_out.oe == 8'h6c)
		else $error("test mode drives wrong bits");
	a_read_clears: assert property ((!host_in.chip_select_n && !host_in.read_strobe_n) [*3]
		|-> result_ready_irq_n) else $error("interrupt not cleared by read");
	a_irq_done: assert property ($fell(result_ready_irq_n) |-> ##[0:2] conversion_done)
		else $error("interrupt without done");
	a_cal_length: assert property (conversion_done && low_reg != 11'h000 && cal_reg
		|-> low_reg == 11'd1399) else $error("calibration length wrong");
	a_null_length: assert property (conversion_done && low_reg != 11'h000 && az_reg
		|-> low_reg == 11'd26) else $error("nulling length wrong");
	a_acq_length: assert property (!conversion_done && high_reg != 11'h000 && acq_reg
		|-> high_reg == 11'd7) else $error("acquisition length wrong");
	a_write_start: assert property ($rose(host_in.write_strobe_n) && !host_in.chip_select_n
		&& host_in.autozero_n && conversion_done |-> ##[1:4] !conversion_done)
		else $error("write rise did not start");
	a_sign_first: assert property ($fell(analog.sign_test) && !conversion_done
		|-> analog.code == 12'h800) else $error("first trial after sign is not the top bit");
endmodule : sac_core_monitor

bind sac_core sac_core_monitor u_mon (
	.mclk              (mclk),
	.srst              (srst),
	.host_in           (host_in),
	.bus_out           (bus_out),
	.conversion_done   (conversion_done),
	.result_ready_irq_n(result_ready_irq_n),
	.comp_high         (comp_high),
	.analog            (analog)
);

// ### bench/sac_afe_model.sv
`timescale 1ns/1ps
module sac_afe_model (
	// Clock
	input wire logic                 mclk,
	// Input voltage and converter side
	input wire logic signed [12:0]   vin,
	input wire sac_pkg::sac_analog_t analog,
	output logic                     comp_high
);
	logic signed [12:0] held_reg;
	logic        [11:0] mag;

	always_ff @(posedge mclk)
	begin
		// Settles within one clock, so whole acquisition periods always suffice
		if (analog.track)
			held_reg <= vin;
	end

	// A tie keeps the trial bit, so the code settles on the magnitude exactly
	assign mag       = held_reg[12] ? 12'(-held_reg) : held_reg[11:0];
	assign comp_high = analog.sign_test ? !held_reg[12] : (mag >= analog.code);
endmodule : sac_afe_model

// ### bench/sar_adc_host_control_test.sv
`timescale 1ns/1ps
module sar_adc_host_control_test;
	logic                  mclk = 1'b0;
	logic                  srst = 1'b1;
	sac_pkg::sac_host_in_t hi = 6'h3f;
	sac_pkg::sac_bus_out_t bus_out;
	sac_pkg::sac_analog_t  analog;
	logic                  conversion_done;
	logic                  result_ready_irq_n;
	logic                  comp_high;
	logic signed [12:0]    vin = 13'h0001;
	int                    n_errors = 0;
	int                    checks = 0;

	always #4 mclk = ~mclk;

	sac_core dut (
		.mclk              (mclk),
		.srst              (srst),
		.host_in           (hi),
		.bus_out           (bus_out),
		.conversion_done   (conversion_done),
		.result_ready_irq_n(result_ready_irq_n),
		.comp_high         (comp_high),
		.analog            (analog)
	);

	sac_afe_model afe (
		.mclk     (mclk),
		.vin      (vin),
		.analog   (analog),
		.comp_high(comp_high)
	);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick

	task chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1)
		begin
			n_errors++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask : chk

	task tally_and_finish;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	task wait_done(input logic lvl, input int lim);
		for (int i = 0; i < lim && conversion_done !== lvl; i++)
			tick(1);
		if (conversion_done !== lvl)
		begin
			n_errors++;
			$display("BAD %0t done wait ran out", $time);
			tally_and_finish;
		end
	endtask : wait_done

	task read_byte(output logic [7:0] d);
		hi.chip_select_n = 1'b0;
		hi.read_strobe_n = 1'b0;
		tick(3);
		d = bus_out.data;
		chk(bus_out.oe === 8'hff, "read not driving");
		hi.read_strobe_n = 1'b1;
		tick(2);
		hi.chip_select_n = 1'b1;
		tick(2);
	endtask : read_byte

	task read_result(input logic [12:0] v);
		logic [7:0] d;
		read_byte(d);
		chk(d === {{3{v[12]}}, v[12:8]}, "high byte");
		chk(result_ready_irq_n === 1'b1, "irq kept");
		read_byte(d);
		chk(d === v[7:0], "low byte");
	endtask : read_result

	task start_wr;
		hi.chip_select_n = 1'b0;
		hi.write_strobe_n = 1'b0;
		tick(2);
		hi.write_strobe_n = 1'b1;
		tick(2);
		hi.chip_select_n = 1'b1;
	endtask : start_wr

	task run_conv(input logic [12:0] v, input logic az, input logic th);
		vin = v;
		hi.autozero_n = az;
		if (th)
		begin
			hi.chip_select_n = 1'b0;
			hi.track_hold_n = 1'b0;
			tick(4);
			hi.track_hold_n = 1'b1;
			tick(2);
			hi.chip_select_n = 1'b1;
		end
		else
			start_wr;
		if (!az)
		begin
			wait_done(1'b0, 10);
			wait_done(1'b1, 40);
		end
		wait_done(1'b0, 20);
		wait_done(1'b1, 40);
		chk(result_ready_irq_n === 1'b0, "no irq at end");
		hi.autozero_n = 1'b1;
		read_result(v);
	endtask : run_conv

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task test_convert;
		logic [12:0] vals [5] = '{13'h0fff, 13'h1001, 13'h0001, 13'h1fff, 13'h00a5};
		foreach (vals[i])
			run_conv(vals[i], 1'b1, 1'b0);
		$display("convert test over");
	endtask : test_convert

	task test_modes;
		run_conv(13'h1234, 1'b0, 1'b0);
		run_conv(13'h0765, 1'b1, 1'b1);
		read_result(13'h0765);
		$display("modes test over");
	endtask : test_modes

	task test_cs_gate;
		hi.write_strobe_n = 1'b0;
		hi.track_hold_n = 1'b0;
		hi.read_strobe_n = 1'b0;
		tick(3);
		hi.write_strobe_n = 1'b1;
		hi.track_hold_n = 1'b1;
		hi.read_strobe_n = 1'b1;
		tick(10);
		chk(conversion_done === 1'b1, "start without select");
		chk(bus_out.oe === 8'h00, "driven without select");
		$display("select test over");
	endtask : test_cs_gate

	task test_test_mode;
		hi.chip_select_n = 1'b0;
		hi.calibrate_n = 1'b0;
		tick(3);
		chk(bus_out.oe === 8'h6c, "test mode bits");
		hi.calibrate_n = 1'b1;
		tick(1);
		hi.chip_select_n = 1'b1;
		tick(2);
		$display("test mode over");
	endtask : test_test_mode

	task test_abort;
		vin = 13'h0100;
		start_wr;
		tick(5);
		chk(conversion_done === 1'b0, "not converting");
		run_conv(13'h0abc, 1'b1, 1'b0);
		$display("abort test over");
	endtask : test_abort

	task test_cal;
		hi.calibrate_n = 1'b0;
		tick(3);
		hi.calibrate_n = 1'b1;
		wait_done(1'b0, 5);
		tick(100);
		start_wr;
		tick(100);
		chk(conversion_done === 1'b0, "calibration cut short");
		wait_done(1'b1, 1400);
		tick(20);
		chk(conversion_done === 1'b1, "stale start after calibration");
		$display("calibration test over");
	endtask : test_cal

	task test_az_restart;
		hi.autozero_n = 1'b0;
		start_wr;
		tick(5);
		chk(conversion_done === 1'b0, "nulling not running");
		run_conv(13'h1abc, 1'b0, 1'b0);
		$display("restart test over");
	endtask : test_az_restart

	initial
	begin
		tick(10);
		srst = 1'b0;
		wait_done(1'b1, 1500);
		test_convert;
		test_modes;
		test_cs_gate;
		test_test_mode;
		test_abort;
		test_cal;
		test_az_restart;
		tally_and_finish;
	end
endmodule : sar_adc_host_control_test
